// ==== verilog/slmc_top.sv ====
// Mode selection and link configuration logic for a two-link serial converter receiver.
// Assumes a byte-wide register port from the serial control port on the same clock.
//
// Overview of operation
// - Upsample code 00, 01, 03, 04 selects 0, 1, 2 or 3 doubling stages.
// - Lock status reads 1 once a reference edge (subclass 1) or internal tick arrives while armed.
// - Modes 8 and 11 accept bypass interpolation only.
// - Modes 8 to 10: one converter, 4/2/1 lanes, matching transmitter counts.
// - Modes 11 to 13: dual link, receiver programmed one converter, half lanes.
// - Link parameters programmed identically on both ends and both links.
// - High density flag is one exactly when frames carry one octet.
// - Resolution and sample bits are 16; K is 32, or 16/32 in 10, 13.
// - Two-link select runs two separately enabled links, else link 0 only.
// - Scrambling flag set enables descrambling of received data.
// - View select steers configuration writes and readbacks to link 0 or 1.
// - Lane enable masks per mode are 0F, 03, 01, FF, 33, 11.
// - A one in the lane power-off mask powers that lane down.
// - Checksum method bit picks field sum or register sum, matching sender.
// - Field sum adds count-minus-one fields except F, plus flags, subclass and version.
// - Register sum adds the eleven packed configuration bytes.
// - Converter power-down code is 5 for two converters, 7 for one.
// - Serializer clock settings follow lane rate band.
// - Link control holds method, two-link, view select and enable mask.
// - Sync machine set up as one-shot, enabled, then armed after links.
// - Subclass 1 aligns to the reference pin; subclass 0 to an internal tick.
`timescale 1ns/1ps
`include "slmc_consts.svh"
module slmc_top
(
  input  logic        clk,
  input  logic        rstn,
  input  logic [11:0] regAddr,
  input  logic        regWrEn,
  input  logic        regRdEn,
  input  logic [7:0]  regWdata,
  output logic [7:0]  regRdata,
  input  logic        sysrefIn,
  input  logic [1:0]  rxCfgValid,
  input  logic [15:0] rxCfgSum,
  output logic [1:0]  upsampleStages,
  output logic [7:0]  laneEnable,
  output logic [7:0]  lanePowerOff,
  output logic [1:0]  linkActive,
  output logic [1:0]  descrambleEn,
  output logic [2:0]  converterPowerDownCode,
  output logic        serdesHalfRate,
  output logic        cdrOversampleSel,
  output logic [1:0]  serdesLoopDivider,
  output logic        syncLocked,
  output logic        lmfcAlign,
  output logic        cfgError
);
  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0]                   syncCtrl_q;
  logic [7:0]                   jesdMode_q;
  logic [7:0]                   upsampleFactorCode_q;
  logic [7:0]                   laneRate_q;
  logic [7:0]                   lanePowerOffValue_q;
  logic [7:0]                   linkCtrl_q;
  logic [7:0]                   subclass_q;
  logic [7:0]                   cfgBank_q [2][`SLMC_CFG_BYTES];
  logic [1:0]                   sumMismatch_q;
  logic [8*`SLMC_CFG_BYTES-1:0] cfgFlat [2];
  logic [7:0]                   localSum [2];
  logic [1:0]                   paramBad;
  logic [11:0]                  cfgOff;
  logic                         cfgHit;
  logic                         linkViewSelect;
  logic                         twoLinkSel;

  assign cfgOff         = regAddr - `SLMC_ADR_CFG_FIRST;
  assign cfgHit         = (regAddr >= `SLMC_ADR_CFG_FIRST) && (regAddr <= `SLMC_ADR_CFG_LAST);
  assign linkViewSelect = linkCtrl_q[`SLMC_LC_VIEW];
  assign twoLinkSel     = linkCtrl_q[`SLMC_LC_TWO_LINK];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      syncCtrl_q           <= `SLMC_RST_BYTE;
      jesdMode_q           <= `SLMC_RST_MODE;
      upsampleFactorCode_q <= `SLMC_IP_BYPASS;
      laneRate_q           <= `SLMC_RST_RATE;
      lanePowerOffValue_q  <= `SLMC_RST_BYTE;
      linkCtrl_q           <= `SLMC_RST_BYTE;
      subclass_q           <= `SLMC_RST_BYTE;
    end
    else if (regWrEn)
    begin
      case (regAddr)
        `SLMC_ADR_SYNC_CTRL: syncCtrl_q           <= regWdata;
        `SLMC_ADR_MODE:      jesdMode_q           <= regWdata;
        `SLMC_ADR_INTERP:    upsampleFactorCode_q <= regWdata;
        `SLMC_ADR_LANE_RATE: laneRate_q           <= regWdata;
        `SLMC_ADR_LANE_OFF:  lanePowerOffValue_q  <= regWdata;
        `SLMC_ADR_LINK_CTRL: linkCtrl_q           <= regWdata;
        `SLMC_ADR_SUBCLASS:  subclass_q           <= regWdata;
        default:             ;
      endcase
    end
  end

  // Configuration writes land in the bank of the link being viewed.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int l = 0; l < 2; l++)
      begin
        for (int i = 0; i < `SLMC_CFG_BYTES; i++)
        begin
          cfgBank_q[l][i] <= `SLMC_RST_BYTE;
        end
      end
    end
    else if (regWrEn && cfgHit)
    begin
      cfgBank_q[linkViewSelect][cfgOff[3:0]] <= regWdata;
    end
  end

  // ****************************************************************
  // Per-link checksum and parameter checks
  // ****************************************************************
  logic [7:0] laneMask;
  logic [4:0] rxLm1;
  logic       modeKnown;
  logic       bypassOnly;
  logic       kFlex;
  logic       oneConv;

  always_comb
  begin
    laneMask   = `SLMC_LANES_8;
    rxLm1      = `SLMC_LM1_4;
    modeKnown  = 1'b1;
    bypassOnly = 1'b0;
    kFlex      = 1'b0;
    oneConv    = 1'b1;
    case (jesdMode_q)
      `SLMC_MODE_8:  bypassOnly = 1'b1;
      `SLMC_MODE_9:  begin laneMask = `SLMC_LANES_9;  rxLm1 = `SLMC_LM1_2; end
      `SLMC_MODE_10: begin laneMask = `SLMC_LANES_10; rxLm1 = `SLMC_LM1_1; kFlex = 1'b1; end
      `SLMC_MODE_11: begin laneMask = `SLMC_LANES_11; bypassOnly = 1'b1; oneConv = 1'b0; end
      `SLMC_MODE_12:
      begin
        laneMask = `SLMC_LANES_12;
        rxLm1    = `SLMC_LM1_2;
        oneConv  = 1'b0;
      end
      `SLMC_MODE_13:
      begin
        laneMask = `SLMC_LANES_13;
        rxLm1    = `SLMC_LM1_1;
        kFlex    = 1'b1;
        oneConv  = 1'b0;
      end
      default: modeKnown = 1'b0;
    endcase
  end

  for (genvar l = 0; l < 2; l++)
  begin : g_link
    slmc_sum_if sumIf ();
    logic [4:0] kM1;
    logic       denseOk;

    always_comb
    begin
      for (int i = 0; i < `SLMC_CFG_BYTES; i++)
      begin
        cfgFlat[l][8*i +: 8] = cfgBank_q[l][i];
      end
    end
    assign sumIf.cfgBytes     = cfgFlat[l];
    assign sumIf.regSumMethod = linkCtrl_q[`SLMC_LC_SUM_METHOD];
    assign localSum[l]        = sumIf.sum;

    slmc_cfg_sum u_sum
    (
      .sumPort (sumIf.calc)
    );

    assign kM1     = cfgBank_q[l][`SLMC_CB_K][`SLMC_CNT_MSB:0];
    assign denseOk = cfgBank_q[l][`SLMC_CB_DENSE][`SLMC_FLAG_BIT]
                  == (cfgBank_q[l][`SLMC_CB_F] == `SLMC_ONE_M1);
    assign paramBad[l] = (cfgBank_q[l][`SLMC_CB_N][`SLMC_CNT_MSB:0] != `SLMC_RES_M1)
                      || (cfgBank_q[l][`SLMC_CB_BPS][`SLMC_CNT_MSB:0] != `SLMC_RES_M1)
                      || ((kM1 != `SLMC_K32_M1) && !(kFlex && kM1 == `SLMC_K16_M1))
                      || (cfgBank_q[l][`SLMC_CB_M] != `SLMC_ONE_M1)
                      || (cfgBank_q[l][`SLMC_CB_L][`SLMC_CNT_MSB:0] != rxLm1)
                      || !denseOk;
  end

  // A mismatch arriving in the clearing cycle is kept.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sumMismatch_q <= 2'h0;
    end
    else
    begin
      for (int l = 0; l < 2; l++)
      begin
        if (rxCfgValid[l] && rxCfgSum[8*l +: 8] != localSum[l])
        begin
          sumMismatch_q[l] <= 1'b1;
        end
        else if (regWrEn && regAddr == `SLMC_ADR_CFG_STAT && regWdata[l])
        begin
          sumMismatch_q[l] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Mode decode and derived outputs
  // ****************************************************************
  logic [1:0] stagesD;
  logic       codeBad;
  logic       modeErr;
  logic       paramErr;
  logic [1:0] linksD;
  slmc_pkg::slmc_band_type band;

  always_comb
  begin
    stagesD = 2'h0;
    codeBad = 1'b0;
    case (upsampleFactorCode_q)
      `SLMC_IP_BYPASS: stagesD = 2'h0;
      `SLMC_IP_X2:     stagesD = 2'h1;
      `SLMC_IP_X4:     stagesD = 2'h2;
      `SLMC_IP_X8:     stagesD = 2'h3;
      default:         codeBad = 1'b1;
    endcase
    modeErr = !modeKnown || codeBad || (bypassOnly && upsampleFactorCode_q != `SLMC_IP_BYPASS);
    paramErr = paramBad[0] || (twoLinkSel && (paramBad[1] || cfgFlat[0] != cfgFlat[1]));
    if (laneRate_q <= `SLMC_RATE_LOW_TOP)
    begin
      band = slmc_pkg::BAND_LOW;
    end
    else if (laneRate_q <= `SLMC_RATE_MID_TOP)
    begin
      band = slmc_pkg::BAND_MID;
    end
    else
    begin
      band = slmc_pkg::BAND_HIGH;
    end
    linksD = linkCtrl_q[`SLMC_LC_EN_MSB:0] & (twoLinkSel ? `SLMC_LINKS_TWO : `SLMC_LINKS_ONE);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      upsampleStages         <= 2'h0;
      laneEnable             <= `SLMC_RST_BYTE;
      linkActive             <= 2'h0;
      descrambleEn           <= 2'h0;
      converterPowerDownCode <= `SLMC_PD_BOTH;
      serdesHalfRate         <= 1'b0;
      cdrOversampleSel       <= 1'b0;
      serdesLoopDivider      <= `SLMC_DIV_HIGH;
      cfgError               <= 1'b0;
    end
    else
    begin
      upsampleStages <= modeErr ? 2'h0 : stagesD;
      laneEnable     <= laneMask;
      linkActive     <= linksD;
      for (int l = 0; l < 2; l++)
      begin
        descrambleEn[l] <= linksD[l] && cfgBank_q[l][`SLMC_CB_L][`SLMC_FLAG_BIT];
      end
      converterPowerDownCode <= (oneConv && !twoLinkSel) ? `SLMC_PD_ONE : `SLMC_PD_BOTH;
      serdesHalfRate    <= (band == slmc_pkg::BAND_HIGH);
      cdrOversampleSel  <= (band == slmc_pkg::BAND_LOW);
      serdesLoopDivider <= (band == slmc_pkg::BAND_LOW) ? `SLMC_DIV_LOW :
                           (band == slmc_pkg::BAND_MID) ? `SLMC_DIV_MID : `SLMC_DIV_HIGH;
      cfgError <= modeErr || paramErr || (|sumMismatch_q);
    end
  end

  assign lanePowerOff = lanePowerOffValue_q;

  // ****************************************************************
  // Frame clock sync machine
  // ****************************************************************
  logic                            sysrefMeta_q;
  logic                            sysrefSync_q;
  logic                            sysrefPrev_q;
  logic [3:0]                      lmfcCnt_q;
  logic                            alignEv;
  logic                            armWr;
  slmc_pkg::slmc_sync_state_type   syncState_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sysrefMeta_q <= 1'b0;
      sysrefSync_q <= 1'b0;
      sysrefPrev_q <= 1'b0;
      lmfcCnt_q    <= 4'h0;
    end
    else
    begin
      sysrefMeta_q <= sysrefIn;
      sysrefSync_q <= sysrefMeta_q;
      sysrefPrev_q <= sysrefSync_q;
      lmfcCnt_q    <= (lmfcCnt_q == `SLMC_LMFC_LAST) ? 4'h0 : lmfcCnt_q + 4'h1;
    end
  end

  assign alignEv = (subclass_q == `SLMC_SUBCLASS_1) ? (sysrefSync_q && !sysrefPrev_q)
                                                   : (lmfcCnt_q == `SLMC_LMFC_LAST);
  assign armWr   = regWrEn && regAddr == `SLMC_ADR_SYNC_CTRL
                && regWdata[`SLMC_SC_ARM] && regWdata[`SLMC_SC_ENABLE];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      syncState_q <= slmc_pkg::SYNC_OFF;
      syncLocked  <= 1'b0;
      lmfcAlign   <= 1'b0;
    end
    else
    begin
      lmfcAlign <= 1'b0;
      case (syncState_q)
        slmc_pkg::SYNC_OFF:
        begin
          syncLocked <= 1'b0;
          if (armWr)
          begin
            syncState_q <= slmc_pkg::SYNC_ARMED;
          end
        end
        slmc_pkg::SYNC_ARMED:
        begin
          if (!syncCtrl_q[`SLMC_SC_ENABLE])
          begin
            syncState_q <= slmc_pkg::SYNC_OFF;
          end
          else if (alignEv)
          begin
            syncState_q <= slmc_pkg::SYNC_LOCKED;
            syncLocked  <= 1'b1;
            lmfcAlign   <= 1'b1;
          end
        end
        slmc_pkg::SYNC_LOCKED:
        begin
          if (!syncCtrl_q[`SLMC_SC_ENABLE])
          begin
            syncState_q <= slmc_pkg::SYNC_OFF;
            syncLocked  <= 1'b0;
          end
          else if (armWr)
          begin
            syncState_q <= slmc_pkg::SYNC_ARMED;
            syncLocked  <= 1'b0;
          end
          else if (alignEv && !syncCtrl_q[`SLMC_SC_ONE_SHOT])
          begin
            lmfcAlign <= 1'b1;
          end
        end
        default: syncState_q <= slmc_pkg::SYNC_OFF;
      endcase
    end
  end

  // ****************************************************************
  // Register readback
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      regRdata <= `SLMC_RST_BYTE;
    end
    else if (regRdEn)
    begin
      regRdata <= `SLMC_RST_BYTE;
      case (regAddr)
        `SLMC_ADR_SYNC_CTRL: regRdata <= syncCtrl_q;
        `SLMC_ADR_SYNC_STAT: regRdata[`SLMC_SS_LOCK] <= syncLocked;
        `SLMC_ADR_MODE:      regRdata <= jesdMode_q;
        `SLMC_ADR_INTERP:    regRdata <= upsampleFactorCode_q;
        `SLMC_ADR_LANE_RATE: regRdata <= laneRate_q;
        `SLMC_ADR_LANE_OFF:  regRdata <= lanePowerOffValue_q;
        `SLMC_ADR_LINK_CTRL: regRdata <= linkCtrl_q;
        `SLMC_ADR_SUBCLASS:  regRdata <= subclass_q;
        `SLMC_ADR_CFG_STAT:
          regRdata <= {4'h0, paramErr, modeErr, sumMismatch_q};
        default:
          if (cfgHit)
          begin
            regRdata <= cfgBank_q[linkViewSelect][cfgOff[3:0]];
          end
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_armed_edge;
    syncState_q == slmc_pkg::SYNC_ARMED && syncCtrl_q[`SLMC_SC_ENABLE] && alignEv;
  endsequence

  a_sync_lock_edge: assert property (s_armed_edge |=> syncLocked && lmfcAlign)
    else $error("lock not reported after reference edge");
  a_interp_x8_map: assert property (upsampleFactorCode_q == `SLMC_IP_X8 && !modeErr
    |=> upsampleStages == 2'h3)
    else $error("8x code did not select three stages");
  a_bypass_only_mode: assert property ((jesdMode_q == `SLMC_MODE_8 || jesdMode_q == `SLMC_MODE_11)
    && upsampleFactorCode_q != `SLMC_IP_BYPASS |=> upsampleStages == 2'h0 && cfgError)
    else $error("interpolation accepted in bypass only mode");
  a_lane_mask_mode: assert property ($stable(jesdMode_q) && jesdMode_q == `SLMC_MODE_12
    |=> laneEnable == `SLMC_LANES_12)
    else $error("wrong lane mask for mode 12");
  a_lane_off_write: assert property (regWrEn && regAddr == `SLMC_ADR_LANE_OFF
    |=> lanePowerOff == $past(regWdata))
    else $error("lane power off mask not taken");
  a_single_link_only: assert property (!twoLinkSel |=> linkActive[1] == 1'b0)
    else $error("link 1 active without two link select");
  a_pd_code_one: assert property (!twoLinkSel && jesdMode_q == `SLMC_MODE_9
    |=> converterPowerDownCode == `SLMC_PD_ONE)
    else $error("power down code not 7 for one converter");
  a_serdes_high_band: assert property (laneRate_q > `SLMC_RATE_MID_TOP
    |=> serdesHalfRate && !cdrOversampleSel && serdesLoopDivider == `SLMC_DIV_HIGH)
    else $error("high band serializer settings wrong");
  a_sum_mismatch_flag: assert property (rxCfgValid[0] && rxCfgSum[7:0] != localSum[0]
    |=> sumMismatch_q[0] ##1 cfgError)
    else $error("checksum mismatch not flagged");
endmodule : slmc_top

// ==== verilog/slmc_consts.svh ====
// Register offsets, field positions, reset values and table values for the link mode block.
// Assumes it is included by bare name from every design file that needs it.
`ifndef SLMC_CONSTS_SVH
`define SLMC_CONSTS_SVH
`define SLMC_ADR_SYNC_CTRL   12'h03A
`define SLMC_ADR_SYNC_STAT   12'h03B
`define SLMC_ADR_MODE        12'h110
`define SLMC_ADR_INTERP      12'h111
`define SLMC_ADR_LANE_RATE   12'h112
`define SLMC_ADR_LANE_OFF    12'h201
`define SLMC_ADR_LINK_CTRL   12'h300
`define SLMC_ADR_SUBCLASS    12'h301
`define SLMC_ADR_CFG_FIRST   12'h450
`define SLMC_ADR_CFG_LAST    12'h45A
`define SLMC_ADR_CFG_STAT    12'h47C
`define SLMC_CFG_BYTES       11
`define SLMC_LC_SUM_METHOD   6
`define SLMC_LC_TWO_LINK     3
`define SLMC_LC_VIEW         2
`define SLMC_LC_EN_MSB       1
`define SLMC_SC_ONE_SHOT     0
`define SLMC_SC_ARM          6
`define SLMC_SC_ENABLE       7
`define SLMC_SS_LOCK         3
`define SLMC_CS_ERR_MODE     2
`define SLMC_CS_ERR_PARAM    3
`define SLMC_CB_L            3
`define SLMC_CB_F            4
`define SLMC_CB_K            5
`define SLMC_CB_M            6
`define SLMC_CB_N            7
`define SLMC_CB_BPS          8
`define SLMC_CB_S            9
`define SLMC_CB_DENSE        10
`define SLMC_FLAG_BIT        7
`define SLMC_CNT_MSB         4
`define SLMC_HI_MSB          7
`define SLMC_RST_BYTE        8'h00
`define SLMC_RST_MODE        8'h08
`define SLMC_RST_RATE        8'h7C
`define SLMC_IP_BYPASS       8'h00
`define SLMC_IP_X2           8'h01
`define SLMC_IP_X4           8'h03
`define SLMC_IP_X8           8'h04
`define SLMC_MODE_8          8'h08
`define SLMC_MODE_9          8'h09
`define SLMC_MODE_10         8'h0A
`define SLMC_MODE_11         8'h0B
`define SLMC_MODE_12         8'h0C
`define SLMC_MODE_13         8'h0D
`define SLMC_LANES_8         8'h0F
`define SLMC_LANES_9         8'h03
`define SLMC_LANES_10        8'h01
`define SLMC_LANES_11        8'hFF
`define SLMC_LANES_12        8'h33
`define SLMC_LANES_13        8'h11
`define SLMC_LM1_4           5'h03
`define SLMC_LM1_2           5'h01
`define SLMC_LM1_1           5'h00
`define SLMC_RES_M1          5'h0F
`define SLMC_K32_M1          5'h1F
`define SLMC_K16_M1          5'h0F
`define SLMC_ONE_M1          8'h00
`define SLMC_SUBCLASS_1      8'h01
`define SLMC_PD_BOTH         3'h5
`define SLMC_PD_ONE          3'h7
`define SLMC_RATE_LOW_TOP    8'h1F
`define SLMC_RATE_MID_TOP    8'h3E
`define SLMC_DIV_LOW         2'h2
`define SLMC_DIV_MID         2'h1
`define SLMC_DIV_HIGH        2'h0
`define SLMC_LINKS_TWO       2'h3
`define SLMC_LINKS_ONE       2'h1
`define SLMC_LMFC_LAST       4'hF
`endif

// ==== verilog/slmc_pkg.sv ====
// Types shared by the link mode block.
// Assumes nothing beyond a SystemVerilog compiler.
package slmc_pkg;
  typedef enum logic [1:0] {SYNC_OFF, SYNC_ARMED, SYNC_LOCKED} slmc_sync_state_type;
  typedef enum logic [1:0] {BAND_LOW, BAND_MID, BAND_HIGH} slmc_band_type;
endpackage : slmc_pkg

// ==== verilog/slmc_sum_if.sv ====
// Carries one link's packed configuration bytes to the checksum calculator and back.
// Assumes the consts header is on the include path.
`timescale 1ns/1ps
`include "slmc_consts.svh"
interface slmc_sum_if;
  logic [8*`SLMC_CFG_BYTES-1:0] cfgBytes;
  logic                         regSumMethod;
  logic [7:0]                   sum;
  modport src  (output cfgBytes, output regSumMethod, input sum);
  modport calc (input cfgBytes, input regSumMethod, output sum);
endinterface : slmc_sum_if

// ==== verilog/slmc_cfg_sum.sv ====
// Combinational lane configuration checksum for one link.
// Assumes bytes are packed lowest offset in the lowest bits.
`timescale 1ns/1ps
`include "slmc_consts.svh"
module slmc_cfg_sum
(
  slmc_sum_if.calc sumPort
);
  logic [7:0] fieldSum;
  logic [7:0] regSum;

  function automatic logic [7:0] cnt(input int idx);
    return {3'h0, sumPort.cfgBytes[8*idx+`SLMC_CNT_MSB -: 5]};
  endfunction : cnt

  function automatic logic [7:0] hi(input int idx);
    return {5'h0, sumPort.cfgBytes[8*idx+`SLMC_HI_MSB -: 3]};
  endfunction : hi

  function automatic logic [7:0] flag(input int idx);
    return {7'h0, sumPort.cfgBytes[8*idx+`SLMC_FLAG_BIT]};
  endfunction : flag

  always_comb
  begin
    regSum = `SLMC_RST_BYTE;
    for (int i = 0; i < `SLMC_CFG_BYTES; i++)
    begin
      regSum = regSum + sumPort.cfgBytes[8*i +: 8];
    end
    fieldSum = cnt(`SLMC_CB_L) + sumPort.cfgBytes[8*`SLMC_CB_M +: 8] + cnt(`SLMC_CB_K)
             + cnt(`SLMC_CB_N) + cnt(`SLMC_CB_BPS) + cnt(`SLMC_CB_S)
             + flag(`SLMC_CB_L) + flag(`SLMC_CB_DENSE)
             + hi(`SLMC_CB_BPS) + hi(`SLMC_CB_S);
    sumPort.sum = sumPort.regSumMethod ? regSum : fieldSum;
  end
endmodule : slmc_cfg_sum

// ==== testbench/slmc_tx_model.sv ====
// Far-side transmitter model: sends per-link checksum pulses and reference edges.
// Assumes the bench requests each transfer just after a rising clock edge.
`timescale 1ns/1ps
module slmc_tx_model
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [1:0]  sendReq,
  input  wire logic [15:0] sumBytes,
  input  wire logic        edgeReq,
  output logic      [1:0]  rxCfgValid,
  output logic      [15:0] rxCfgSum,
  output logic             sysrefIn
);
  // Idle sum lines toggle every cycle so a stale value never passes for a sent one.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rxCfgValid <= 2'h0;
      rxCfgSum   <= 16'hA5A5;
      sysrefIn   <= 1'b0;
    end
    else
    begin
      rxCfgValid <= sendReq;
      rxCfgSum   <= (sendReq != 2'h0) ? sumBytes : ~rxCfgSum;
      sysrefIn   <= edgeReq;
    end
  end
endmodule : slmc_tx_model

// ==== testbench/serial_link_mode_config_test.sv ====
// Self-checking bench for the link mode block with a transmitter model beside it.
// Assumes the design files and the consts header are compiled first.
`timescale 1ns/1ps
module serial_link_mode_config_test;
  logic clk = 1'b0, rstn = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0, edgeReq = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0]  regWdata = 8'h00, regRdata, laneEnable, lanePowerOff, rd, v;
  logic [1:0]  rxCfgValid, upsampleStages, linkActive, serdesLoopDivider, descr, sendReq = 2'h0;
  logic [15:0] rxCfgSum, sumBytes = 16'h0000;
  logic [2:0]  pdCode;
  logic        sysrefIn, serdesHalfRate, cdrOversampleSel, syncLocked, lmfcAlign, cfgErr;
  int          err_total = 0, checked = 0, i;
  integer      seed = 32'hF263D9B8;
  always #5 clk = ~clk;
  slmc_tx_model i_slmc_tx_model (.clk(clk), .rstn(rstn), .sendReq(sendReq), .sumBytes(sumBytes),
    .edgeReq(edgeReq), .rxCfgValid(rxCfgValid), .rxCfgSum(rxCfgSum), .sysrefIn(sysrefIn));
  slmc_top i_slmc_top (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWdata(regWdata), .regRdata(regRdata), .sysrefIn(sysrefIn),
    .rxCfgValid(rxCfgValid), .rxCfgSum(rxCfgSum), .upsampleStages(upsampleStages),
    .laneEnable(laneEnable), .lanePowerOff(lanePowerOff), .linkActive(linkActive),
    .descrambleEn(descr), .converterPowerDownCode(pdCode), .serdesHalfRate(serdesHalfRate),
    .cdrOversampleSel(cdrOversampleSel), .serdesLoopDivider(serdesLoopDivider),
    .syncLocked(syncLocked), .lmfcAlign(lmfcAlign), .cfgError(cfgErr));
  // ****************************************
  // Bus tasks, expectations and checking
  // ****************************************
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    regAddr = a;
    regWdata = d;
    regWrEn = 1'b1;
    @(posedge clk);
    #1 regWrEn = 1'b0;
    @(posedge clk);
    #1;
  endtask : wr
  task automatic rdr(input logic [11:0] a);
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge clk);
    #1 regRdEn = 1'b0;
    @(posedge clk);
    #1 rd = regRdata;
  endtask : rdr
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  function automatic logic [7:0] laneExp(input int m);
    logic [7:0] t [6] = '{8'h0F, 8'h03, 8'h01, 8'hFF, 8'h33, 8'h11};
    return t[m-8];
  endfunction : laneExp
  function automatic logic [7:0] bandExp(input logic [7:0] r);
    return (r <= 8'h1F) ? 8'h06 : ((r <= 8'h3E) ? 8'h01 : 8'h08);
  endfunction : bandExp
  task automatic summarize;
    $display("TB: checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    settle;
    chk("lanes", laneEnable, 8'h0F);
    chk("cfgErrRst", {7'h0, cfgErr}, 8'h01);
    for (i = 0; i < 6; i++)
    begin
      v = 8'h0E + 8'($unsigned($random(seed)) % 111);
      v = (i == 0) ? 8'h1F : ((i == 1) ? 8'h3E : ((i == 2) ? 8'h0E : v));
      wr(12'h112, v);
      settle;
      chk("band", {4'h0, serdesHalfRate, cdrOversampleSel, serdesLoopDivider}, bandExp(v));
    end
    $display("test bands done");
    v = $random(seed);
    wr(12'h201, v);
    settle;
    chk("powerOff", lanePowerOff, v);
    rdr(12'h201);
    chk("powerOffRd", rd, v);
    rdr(12'h7FF);
    chk("unmapped", rd, 8'h00);
    for (i = 8; i < 14; i++)
    begin
      wr(12'h110, 8'(i));
      wr(12'h111, 8'h00);
      settle;
      chk("modeLanes", laneEnable, laneExp(i));
      chk("pdSingle", 8'(pdCode), (i < 11) ? 8'h07 : 8'h05);
    end
    wr(12'h110, 8'h09);
    for (i = 0; i < 4; i++)
    begin
      wr(12'h111, (i == 0) ? 8'h00 : 8'(i + 1 - (i == 1)));
      settle;
      chk("stages", 8'(upsampleStages), 8'(i));
    end
    wr(12'h110, 8'h08);
    settle;
    chk("mode8Interp", 8'(upsampleStages), 8'h00);
    rdr(12'h47C);
    chk("modeErr", rd & 8'h04, 8'h04);
    $display("test modes done");
    wr(12'h110, 8'h09);
    wr(12'h300, 8'h0B);
    settle;
    chk("links", 8'(linkActive), 8'h03);
    chk("pdDual", 8'(pdCode), 8'h05);
    sumBytes = {8'h00, 8'h01 | 8'($random(seed))};
    sendReq = 2'h3;
    @(posedge clk);
    #1 sendReq = 2'h0;
    settle;
    rdr(12'h47C);
    chk("sumFlag", rd & 8'h03, 8'h01);
    wr(12'h47C, 8'h01);
    rdr(12'h47C);
    chk("sumClear", rd & 8'h03, 8'h00);
    wr(12'h453, 8'h80);
    settle;
    chk("descramble", 8'(descr), 8'h01);
    wr(12'h300, 8'h0F);
    rdr(12'h453);
    chk("viewBank1", rd, 8'h00);
    $display("test checksum done");
    wr(12'h301, 8'h01);
    wr(12'h03A, 8'h01);
    wr(12'h03A, 8'h81);
    wr(12'h03A, 8'hC1);
    settle;
    chk("notLocked", 8'(syncLocked), 8'h00);
    edgeReq = 1'b1;
    for (i = 0; i < 20 && syncLocked !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("lockWait", {7'h0, syncLocked}, 8'h01);
    chk("align", {7'h0, lmfcAlign}, 8'h01);
    edgeReq = 1'b0;
    rdr(12'h03B);
    chk("lockStat", rd & 8'h08, 8'h08);
    $display("test sync done");
    summarize;
  end
endmodule : serial_link_mode_config_test
